// file: src/phsf_pkg.sv
// Package for the PTP timing event and policing block.
// Assumes a single 100 MHz clock with a synchronous active-high reset.
package phsf_pkg;

  // ----------------------------------------------------------------
  // Field widths
  // ----------------------------------------------------------------
  localparam int MSG_TYPE_W = 4;
  localparam int BUF_IDX_W  = 2;
  localparam int EVT_CNT_W  = 16;
  localparam int CREDIT_W   = 8;

  // ----------------------------------------------------------------
  // Message type codes
  // ----------------------------------------------------------------
  localparam logic [MSG_TYPE_W-1:0] MSG_SYNC      = 4'h0;
  localparam logic [MSG_TYPE_W-1:0] MSG_FOLLOW_UP = 4'h8;

  // ----------------------------------------------------------------
  // Bandwidth policing: stream share is RATE_NUM / RATE_DEN
  // ----------------------------------------------------------------
  localparam int                    RATE_NUM   = 3;
  localparam int                    RATE_DEN   = 4;
  localparam logic [CREDIT_W-1:0]   CREDIT_MAX = 8'h10;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CREDIT_W-1:0]   CREDIT_RST = 8'h00;
  localparam logic [EVT_CNT_W-1:0]  CNT_RST    = 16'h0000;
  localparam logic [MSG_TYPE_W-1:0] TYPE_RST   = 4'h0;
  localparam logic [BUF_IDX_W-1:0]  BUF_RST    = 2'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  done;
    logic [MSG_TYPE_W-1:0] msg_type;
  } phsf_tx_evt_s;

  typedef struct packed {
    logic                 done;
    logic [BUF_IDX_W-1:0] buf_idx;
  } phsf_rx_evt_s;

  typedef struct packed {
    logic                  pending;
    logic                  lost;
    logic [MSG_TYPE_W-1:0] msg_type;
  } phsf_tx_stat_s;

  typedef struct packed {
    logic                 pending;
    logic                 lost;
    logic [BUF_IDX_W-1:0] buf_idx;
  } phsf_rx_stat_s;

endpackage

// file: src/phsf_policer.sv
// Credit policer limiting stream bytes to a fixed share of line slots.
// Assumes one line byte slot per clock and requests from the same clock.
`timescale 1ns/1ps
module phsf_policer
  import phsf_pkg::*;
#(
  parameter int                  NUM  = RATE_NUM,
  parameter int                  DEN  = RATE_DEN,
  parameter logic [CREDIT_W-1:0] CMAX = CREDIT_MAX
)(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic av_valid_i,
  output logic      av_grant_o
);
  import phsf_pkg::*;

  localparam logic signed [CREDIT_W:0] ADD_C = (CREDIT_W+1)'(NUM);
  localparam logic signed [CREDIT_W:0] SUB_C = (CREDIT_W+1)'(DEN);
  localparam logic signed [CREDIT_W:0] MAX_C = {1'b0, CMAX};

  logic signed [CREDIT_W:0] credit_ff;
  logic signed [CREDIT_W:0] nxt_credit;
  logic                     grant_ff;
  logic                     nxt_grant;
  logic signed [CREDIT_W:0] sum;

  // ----------------------------------------------------------------
  // Credit update: gain NUM per slot, pay DEN per byte sent
  // ----------------------------------------------------------------
  always_comb
  begin
    sum = credit_ff + ADD_C;
    if (av_valid_i && grant_ff)
      sum = sum - SUB_C;
    nxt_credit = (sum > MAX_C) ? MAX_C : sum;
    nxt_grant  = (nxt_credit >= 0);
  end

  // Registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      credit_ff <= {1'b0, CREDIT_RST};
      grant_ff  <= 1'b0;
    end
    else
    begin
      credit_ff <= nxt_credit;
      grant_ff  <= nxt_grant;
    end
  end

  assign av_grant_o = grant_ff;

endmodule

// file: src/phsf_core.sv
// Timing event status and interrupt logic of the bridging endpoint,
// with stream bandwidth policing.
// Assumes events, read strobes and stream requests come from logic
// on clk_i; the host services interrupts one at a time.
// Event counters wrap; status words hold until the next read.
// An event in the cycle of a read wins: the interrupt stays up.
`timescale 1ns/1ps
module phsf_core
  import phsf_pkg::*;
(
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire phsf_pkg::phsf_tx_evt_s        tx_evt_i,
  input  wire phsf_pkg::phsf_rx_evt_s        rx_evt_i,
  input  wire logic                          tx_stat_rd_i,
  input  wire logic                          rx_stat_rd_i,
  input  wire logic                          av_valid_i,
  output logic                               irq_tx_o,
  output logic                               irq_rx_o,
  output phsf_pkg::phsf_tx_stat_s            tx_stat_o,
  output phsf_pkg::phsf_rx_stat_s            rx_stat_o,
  output logic                               tx_stat_vld_o,
  output logic                               rx_stat_vld_o,
  output logic [phsf_pkg::EVT_CNT_W-1:0]     tx_cnt_o,
  output logic [phsf_pkg::EVT_CNT_W-1:0]     rx_cnt_o,
  output logic                               av_grant_o
);
  import phsf_pkg::*;

  // ----------------------------------------------------------------
  // Transmit side state
  // ----------------------------------------------------------------
  // Pending and lost flags, last message type
  logic                  tx_pend_ff;
  logic                  nxt_tx_pend;
  logic                  tx_lost_ff;
  logic                  nxt_tx_lost;
  logic [MSG_TYPE_W-1:0] tx_type_ff;
  logic [MSG_TYPE_W-1:0] nxt_tx_type;
  // Held read word and its valid pulse
  phsf_tx_stat_s         tx_rdat_ff;
  phsf_tx_stat_s         nxt_tx_rdat;
  logic                  tx_rvld_ff;
  logic                  nxt_tx_rvld;
  // Transmitted PTP frame counter
  logic [EVT_CNT_W-1:0]  tx_cnt_ff;
  logic [EVT_CNT_W-1:0]  nxt_tx_cnt;

  // ----------------------------------------------------------------
  // Receive side state
  // ----------------------------------------------------------------
  // Pending and lost flags, last buffer index
  logic                  rx_pend_ff;
  logic                  nxt_rx_pend;
  logic                  rx_lost_ff;
  logic                  nxt_rx_lost;
  logic [BUF_IDX_W-1:0]  rx_buf_ff;
  logic [BUF_IDX_W-1:0]  nxt_rx_buf;
  // Held read word and its valid pulse
  phsf_rx_stat_s         rx_rdat_ff;
  phsf_rx_stat_s         nxt_rx_rdat;
  logic                  rx_rvld_ff;
  logic                  nxt_rx_rvld;
  // Received PTP frame counter
  logic [EVT_CNT_W-1:0]  rx_cnt_ff;
  logic [EVT_CNT_W-1:0]  nxt_rx_cnt;

  // ----------------------------------------------------------------
  // Transmit status and interrupt
  // ----------------------------------------------------------------
  // New event sets pending; a read clears it; set wins over clear
  always_comb
  begin
    nxt_tx_pend = tx_pend_ff;
    nxt_tx_lost = tx_lost_ff;
    nxt_tx_type = tx_type_ff;
    nxt_tx_cnt  = tx_cnt_ff;
    nxt_tx_rdat = tx_rdat_ff;
    nxt_tx_rvld = tx_stat_rd_i;
    // Read takes the state as it stood, then clears it
    if (tx_stat_rd_i)
    begin
      nxt_tx_rdat = '{pending: tx_pend_ff, lost: tx_lost_ff, msg_type: tx_type_ff};
      nxt_tx_pend = 1'b0;
      nxt_tx_lost = 1'b0;
    end
    // Event comes after the read so that the set wins
    if (tx_evt_i.done)
    begin
      if (tx_pend_ff && !tx_stat_rd_i)
        nxt_tx_lost = 1'b1;                        // Overwrote unread status
      nxt_tx_pend = 1'b1;
      nxt_tx_type = tx_evt_i.msg_type;
      nxt_tx_cnt  = tx_cnt_ff + 16'h0001;
    end
  end

  // Transmit registers
  // Reset clears status, counter and the held read word
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_pend_ff <= 1'b0;
      tx_lost_ff <= 1'b0;
      tx_type_ff <= TYPE_RST;
      tx_cnt_ff  <= CNT_RST;
      tx_rdat_ff <= '0;
      tx_rvld_ff <= 1'b0;
    end
    else
    begin
      tx_pend_ff <= nxt_tx_pend;
      tx_lost_ff <= nxt_tx_lost;
      tx_type_ff <= nxt_tx_type;
      tx_cnt_ff  <= nxt_tx_cnt;
      tx_rdat_ff <= nxt_tx_rdat;
      tx_rvld_ff <= nxt_tx_rvld;
    end
  end

  // ----------------------------------------------------------------
  // Receive status and interrupt
  // ----------------------------------------------------------------
  // Same scheme as transmit; buffer index replaces message type
  always_comb
  begin
    nxt_rx_pend = rx_pend_ff;
    nxt_rx_lost = rx_lost_ff;
    nxt_rx_buf  = rx_buf_ff;
    nxt_rx_cnt  = rx_cnt_ff;
    nxt_rx_rdat = rx_rdat_ff;
    nxt_rx_rvld = rx_stat_rd_i;
    // Read takes the state as it stood, then clears it
    if (rx_stat_rd_i)
    begin
      nxt_rx_rdat = '{pending: rx_pend_ff, lost: rx_lost_ff, buf_idx: rx_buf_ff};
      nxt_rx_pend = 1'b0;
      nxt_rx_lost = 1'b0;
    end
    // Event comes after the read so that the set wins
    if (rx_evt_i.done)
    begin
      if (rx_pend_ff && !rx_stat_rd_i)
        nxt_rx_lost = 1'b1;                        // Overwrote unread status
      nxt_rx_pend = 1'b1;
      nxt_rx_buf  = rx_evt_i.buf_idx;
      nxt_rx_cnt  = rx_cnt_ff + 16'h0001;
    end
  end

  // Receive registers
  // Reset clears status, counter and the held read word
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_pend_ff <= 1'b0;
      rx_lost_ff <= 1'b0;
      rx_buf_ff  <= BUF_RST;
      rx_cnt_ff  <= CNT_RST;
      rx_rdat_ff <= '0;
      rx_rvld_ff <= 1'b0;
    end
    else
    begin
      rx_pend_ff <= nxt_rx_pend;
      rx_lost_ff <= nxt_rx_lost;
      rx_buf_ff  <= nxt_rx_buf;
      rx_cnt_ff  <= nxt_rx_cnt;
      rx_rdat_ff <= nxt_rx_rdat;
      rx_rvld_ff <= nxt_rx_rvld;
    end
  end

  // ----------------------------------------------------------------
  // Stream bandwidth policing
  // ----------------------------------------------------------------
  // Grant comes registered out of the policer
  // Credit is signed: a granted byte may overdraw it by one,
  // which then holds the grant low for a single slot
  phsf_policer #(
    .NUM  (RATE_NUM),
    .DEN  (RATE_DEN),
    .CMAX (CREDIT_MAX)
  ) u_policer (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .av_valid_i (av_valid_i),
    .av_grant_o (av_grant_o)
  );

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  // Interrupts follow the pending flags
  assign irq_tx_o      = tx_pend_ff;
  assign irq_rx_o      = rx_pend_ff;

  // Held read words and their valid pulses
  assign tx_stat_o     = tx_rdat_ff;
  assign rx_stat_o     = rx_rdat_ff;
  assign tx_stat_vld_o = tx_rvld_ff;
  assign rx_stat_vld_o = rx_rvld_ff;

  // Event counters
  assign tx_cnt_o      = tx_cnt_ff;
  assign rx_cnt_o      = rx_cnt_ff;

endmodule

// file: tb/phsf_core_props.sv
// Checker for the timing event and policing block.
// Assumes binding onto phsf_core; sees only its ports.
`timescale 1ns/1ps
module phsf_core_props
  import phsf_pkg::*;
(
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire phsf_pkg::phsf_tx_evt_s  tx_evt_i,
  input wire phsf_pkg::phsf_rx_evt_s  rx_evt_i,
  input wire logic                    tx_stat_rd_i,
  input wire logic                    rx_stat_rd_i,
  input wire logic                    av_valid_i,
  input wire logic                    irq_tx_o,
  input wire logic                    irq_rx_o,
  input wire phsf_pkg::phsf_tx_stat_s tx_stat_o,
  input wire phsf_pkg::phsf_rx_stat_s rx_stat_o,
  input wire logic                    tx_stat_vld_o,
  input wire logic                    rx_stat_vld_o,
  input wire logic [15:0]             tx_cnt_o,
  input wire logic                    av_grant_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Length of the current run of granted bytes
  logic [7:0] run_ff;
  logic [7:0] nxt_run;
  always_comb nxt_run = (av_valid_i && av_grant_o) ? run_ff + 8'h01 : 8'h00;
  always_ff @(posedge clk_i) run_ff <= rst_i ? 8'h00 : nxt_run;
  // Event, a quiet cycle, then a clean status read, as the host answers
  sequence s_tx_rd;
    tx_evt_i.done ##1 !tx_evt_i.done ##1 (tx_stat_rd_i && !tx_evt_i.done);
  endsequence
  sequence s_rx_rd;
    rx_evt_i.done ##1 !rx_evt_i.done ##1 (rx_stat_rd_i && !rx_evt_i.done);
  endsequence
  a_tx_irq_set: assert property (tx_evt_i.done |=> irq_tx_o && tx_cnt_o == $past(tx_cnt_o) + 16'h0001)
    else $error("tx interrupt or count missing");
  a_tx_irq_hold: assert property (irq_tx_o && !tx_stat_rd_i |=> irq_tx_o)
    else $error("tx interrupt dropped unread");
  a_tx_rd_clr: assert property (tx_stat_rd_i && !tx_evt_i.done |=> !irq_tx_o && tx_stat_vld_o)
    else $error("tx read did not clear");
  a_tx_type_seen: assert property (s_tx_rd |=> tx_stat_o.msg_type == $past(tx_evt_i.msg_type, 3))
    else $error("tx type wrong");
  a_rx_irq_set: assert property (rx_evt_i.done |=> irq_rx_o)
    else $error("rx interrupt missing");
  a_rx_rd_clr: assert property (rx_stat_rd_i && !rx_evt_i.done |=> !irq_rx_o && rx_stat_vld_o)
    else $error("rx read did not clear");
  a_rx_buf_seen: assert property (s_rx_rd |=> rx_stat_o.pending && rx_stat_o.buf_idx == $past(rx_evt_i.buf_idx, 3))
    else $error("rx buffer index wrong");
  // Full bucket of 16 credits pays for at most 17 bytes in a row
  a_av_burst_max: assert property (run_ff <= 8'h11)
    else $error("stream burst too long");
endmodule

bind phsf_core phsf_core_props chk_u (.clk_i, .rst_i, .tx_evt_i, .rx_evt_i, .tx_stat_rd_i, .rx_stat_rd_i,
  .av_valid_i, .irq_tx_o, .irq_rx_o, .tx_stat_o, .rx_stat_o, .tx_stat_vld_o, .rx_stat_vld_o, .tx_cnt_o, .av_grant_o);

// file: tb/phsf_host_model.sv
// Host service model: reads status on interrupt, one at a time.
// Assumes status valid pulses one cycle after each read.
`timescale 1ns/1ps
module phsf_host_model
  import phsf_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    en_i,
  input  wire logic                    irq_tx_i,
  input  wire logic                    irq_rx_i,
  input  wire logic                    tx_vld_i,
  input  wire logic                    rx_vld_i,
  input  wire phsf_pkg::phsf_tx_stat_s tx_stat_i,
  output logic                         tx_rd_o,
  output logic                         rx_rd_o,
  output logic                         fu_req_o
);
  logic       busy_ff;
  logic [1:0] init_ff;
  logic       svc;
  // Service only once the setup count in init_ff has reached 3
  assign svc = en_i && (init_ff == 2'h3);
  // Setup phase after reset, then service loop, transmit first
  always_ff @(posedge clk_i)
  begin
    init_ff  <= rst_i ? 2'h0 : init_ff + {1'b0, init_ff != 2'h3};
    tx_rd_o  <= !rst_i && svc && !busy_ff && irq_tx_i;
    rx_rd_o  <= !rst_i && svc && !busy_ff && !irq_tx_i && irq_rx_i;
    fu_req_o <= !rst_i && tx_vld_i && tx_stat_i.msg_type == MSG_SYNC;
    busy_ff  <= !rst_i && (busy_ff ? !(tx_vld_i || rx_vld_i) : svc && (irq_tx_i || irq_rx_i));
  end
endmodule

// file: tb/tb.sv
// Testbench for the timing event and policing block.
// Assumes host model services interrupts; bench drives events.
`timescale 1ns/1ps
module tb;
  import phsf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  phsf_tx_evt_s tx_evt_i = '0;
  phsf_rx_evt_s rx_evt_i = '0;
  logic tx_stat_rd_i, rx_stat_rd_i, tx_stat_vld_o, rx_stat_vld_o, irq_tx_o, irq_rx_o, av_grant_o, fu;
  logic av_valid_i = 1'b0;
  logic en = 1'b1;
  phsf_tx_stat_s tx_stat_o;
  phsf_rx_stat_s rx_stat_o;
  logic [15:0] tx_cnt_o, rx_cnt_o;
  int miscompares = 0;
  int checked = 0;
  int txn = 0;
  int rxn = 0;
  phsf_core dut_u (.clk_i, .rst_i, .tx_evt_i, .rx_evt_i, .tx_stat_rd_i, .rx_stat_rd_i, .av_valid_i, .irq_tx_o,
    .irq_rx_o, .tx_stat_o, .rx_stat_o, .tx_stat_vld_o, .rx_stat_vld_o, .tx_cnt_o, .rx_cnt_o, .av_grant_o);
  phsf_host_model host_u (.clk_i, .rst_i, .en_i(en), .irq_tx_i(irq_tx_o), .irq_rx_i(irq_rx_o),
    .tx_vld_i(tx_stat_vld_o), .rx_vld_i(rx_stat_vld_o), .tx_stat_i(tx_stat_o), .tx_rd_o(tx_stat_rd_i),
    .rx_rd_o(rx_stat_rd_i), .fu_req_o(fu));
  initial forever #5 clk_i = ~clk_i;
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Bounded wait for a status valid pulse
  task automatic wait_vld(input logic rx);
    int i;
    for (i = 0; i < 20 && (rx ? rx_stat_vld_o : tx_stat_vld_o) !== 1'b1; i++)
      tick(1);
    if (i == 20)
    begin
      miscompares++;
      results();
    end
  endtask
  // Continuous stream offer from reset
  task automatic t_police;
    int sent;
    sent = 0;
    av_valid_i = 1'b1;
    repeat (400)
    begin
      tick(1);
      sent += (av_grant_o === 1'b1);
    end
    av_valid_i = 1'b0;
    check("av share", sent >= 296 && sent <= 304, 16'h0001);
    // Idle until the credit bucket is full, then a fresh burst
    tick(10);
    av_valid_i = 1'b1;
    sent = 0;
    while (av_grant_o === 1'b1 && sent < 40)
    begin
      sent++;
      tick(1);
    end
    av_valid_i = 1'b0;
    check("av burst", sent[15:0], 16'(CREDIT_MAX) + 16'h0001);
  endtask
  // Transmit event of one type, serviced by host
  task automatic t_tx(input logic [3:0] code);
    tx_evt_i = '{1'b1, code};
    tick(1);
    tx_evt_i.done = 1'b0;
    txn++;
    check("irq_tx set", irq_tx_o, 16'h0001);
    check("tx_cnt", tx_cnt_o, txn[15:0]);
    wait_vld(1'b0);
    check("irq_tx clr", irq_tx_o, 16'h0000);
    check("tx type", tx_stat_o.msg_type, code);
    tick(1);
    check("follow up", fu, code == MSG_SYNC);
  endtask
  // Receive event into one buffer
  task automatic t_rx(input logic [1:0] b);
    rx_evt_i = '{1'b1, b};
    tick(1);
    rx_evt_i.done = 1'b0;
    rxn++;
    check("irq_rx set", irq_rx_o, 16'h0001);
    check("rx_cnt", rx_cnt_o, rxn[15:0]);
    wait_vld(1'b1);
    check("irq_rx clr", irq_rx_o, 16'h0000);
    check("rx buf", rx_stat_o.buf_idx, b);
    tick(1);
  endtask
  // Two events back to back before any read
  task automatic t_lost;
    en = 1'b0;
    tx_evt_i = '{1'b1, MSG_SYNC};
    tick(1);
    tx_evt_i.msg_type = MSG_FOLLOW_UP;
    tick(1);
    tx_evt_i.done = 1'b0;
    tick(3);
    check("irq_tx held", irq_tx_o, 16'h0001);
    en = 1'b1;
    wait_vld(1'b0);
    check("tx lost", {tx_stat_o.lost, tx_stat_o.msg_type}, {1'b1, MSG_FOLLOW_UP});
    check("irq_tx clr2", irq_tx_o, 16'h0000);
    tick(2);
  endtask
  initial
  begin
    repeat (2) @(posedge clk_i);
    #1;
    check("reset irq", {13'h0000, irq_tx_o, irq_rx_o, av_grant_o}, 16'h0000);
    check("reset cnt", tx_cnt_o | rx_cnt_o, 16'h0000);
    rst_i = 1'b0;
    t_police();
    t_tx(MSG_SYNC);
    t_tx(MSG_FOLLOW_UP);
    for (int b = 0; b < 4; b++)
      t_rx(b[1:0]);
    t_lost();
    results();
  end
endmodule
